//--- design/fp_pair_pkg.sv
// shared types and constants for the paired single-precision unit
// assumes one core clock, synchronous active-high reset
package fp_pair_pkg;

    // operation select, one-hot
    typedef enum logic [3:0] {
        OP_NMSUB  = 4'h1,
        OP_SQRT   = 4'h2,
        OP_SUB    = 4'h4,
        OP_SUBADD = 4'h8
    } fp_op_e;

    // rounding mode field encodings
    localparam logic [1:0] ROUND_NEAREST     = 2'h0;
    localparam logic [1:0] ROUND_TOWARD_ZERO = 2'h1;
    localparam logic [1:0] ROUND_PLUS_INF    = 2'h2;
    localparam logic [1:0] ROUND_MINUS_INF   = 2'h3;

    // register offsets on the plain register port
    localparam logic [3:0] OFS_FPSCR    = 4'h0;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h4;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h8;

    // interrupt status bit positions
    localparam int IRQ_INVALID = 0;
    localparam int IRQ_OVF_UNF = 1;
    localparam int IRQ_ROUND   = 2;
    localparam int IRQ_DONE    = 3;
    localparam logic [3:0] IRQ_RESET = 4'h0;

    // float encoding constants
    localparam logic [7:0]  EXP_SPECIAL = 8'hFF;
    localparam logic [10:0] EXP_BIAS    = 11'h07F;
    localparam logic [10:0] EXP_LIMIT   = 11'h0FF;
    localparam logic [30:0] MAX_MAG     = 31'h7F7FFFFF;

    // status/control register layout
    typedef struct packed {
        logic [9:0] rsv_hi;
        logic [1:0] rmode;
        logic       inexact_exc_enable;
        logic       underflow_exc_enable;
        logic       overflow_exc_enable;
        logic       invalid_exc_enable;
        logic [3:0] rsv_mid;
        logic       inexact_sticky_high;
        logic       inexact_sticky_low;
        logic       sticky_bit_high;
        logic       guard_bit_high;
        logic       sticky_bit_low;
        logic       guard_bit_low;
        logic       underflow_flag_high;
        logic       underflow_flag_low;
        logic       overflow_flag_high;
        logic       overflow_flag_low;
        logic       invalid_flag_high;
        logic       invalid_flag_low;
    } fpscr_s;

    localparam logic [31:0] FPSCR_RESET = 32'h00000000;

    // one issued operation
    typedef struct packed {
        fp_op_e      op;
        logic [63:0] src_a;
        logic [63:0] src_b;
        logic [63:0] src_d;
    } fp_issue_s;

    // unpacked intermediate number, unbounded biased exponent
    typedef struct packed {
        logic        sign;
        logic        zero;
        logic [10:0] exp;
        logic [23:0] mant;
        logic        g;
        logic        x;
    } fp_num_s;

    // per-element outcome
    typedef struct packed {
        logic [31:0] val;
        logic        inv;
        logic        ovf;
        logic        unf;
        logic        inx;
        logic        g;
        logic        x;
    } fp_elem_s;

endpackage

//--- design/fp_pair_unit.sv
// paired single-precision datapath: nmsub, sqrt, sub, subadd
// assumes a synchronous issue port
// Function
// - nmsub: negate product minus destination element
// - zero or denormal multiplicand gives the destination element, or signed zero if it is zero
// - special multiplicand: signed max product, negated
// - special accumulator: max value by its sign
// - nmsub underflow: minus zero, plus under minus-inf
// - overflow stores signed largest normal value
// - sqrt per element; zero/denormal keeps sign
// - sqrt: positive special max, negative gives -0
// - other underflow: plus zero, minus under minus-inf
// - sqrt negative nonzero input is invalid
// - sub: special operand gives signed max value
// - subadd: subtract high element, add low element
// - invalid input flags, clears guard, may cancel write
// - overflow/underflow flags; enabled ones cancel write
// - inexact sticky on inexact or untrapped ovf/unf
// - inexact trap writes truncated result, keeps guard
// - guard/sticky cleared on ovf/unf trap or invalid element
// - sqrt never overflows, sets both inexact stickies
`timescale 1ns/10ps
module fp_pair_unit
    import fp_pair_pkg::*;
(
    // clock, reset, enable
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    // issue from the core
    input  wire logic        issue_valid,
    input  wire fp_issue_s   issue,
    // write-back to the register file
    output logic             result_valid_q,
    output logic             result_we_q,
    output logic [63:0]      result_q,
    // exception requests
    output logic             exc_invalid_q,
    output logic             exc_ovf_unf_q,
    output logic             exc_round_q,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata_q,
    // interrupt line
    output logic             irq_q
);

    fpscr_s      fpscr_q;        // status/control register
    logic [3:0]  irq_stat_q;     // sticky event bits
    logic [3:0]  irq_mask_q;     // event enables
    fp_elem_s    el_hi;          // element bits 63:32
    fp_elem_s    el_lo;          // element bits 31:0
    logic        any_inv;
    logic        take_inv;
    logic        take_ou;
    logic        inx_hi;
    logic        inx_lo;
    logic        take_rnd;
    logic        do_write;
    logic [3:0]  events;

    // input classification helpers
    function automatic logic f_special(input logic [31:0] v);
        return v[30:23] == EXP_SPECIAL;
    endfunction

    function automatic logic f_zd(input logic [31:0] v);
        return v[30:23] == 8'h00;
    endfunction

    function automatic logic f_bad(input logic [31:0] v);
        return f_special(v) || (f_zd(v) && v[22:0] != 23'h0);
    endfunction

    // signed largest normal value
    function automatic logic [31:0] f_max(input logic s);
        return {s, MAX_MAG};
    endfunction

    // denormals collapse to zero here; they are flagged invalid anyway
    function automatic fp_num_s f_unpack(input logic [31:0] v,
                                         input logic flip);
        fp_num_s n;
        n.sign = v[31] ^ flip;
        n.zero = f_zd(v);
        n.exp  = {3'h0, v[30:23]};
        n.mant = {1'b1, v[22:0]};
        n.g    = 1'b0;
        n.x    = 1'b0;
        return n;
    endfunction

    // truncating multiply, exponent left unbounded
    function automatic fp_num_s f_mul(input logic [31:0] a,
                                      input logic [31:0] b);
        fp_num_s     n;
        logic [47:0] p;
        n = '0;
        p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
        n.sign = a[31] ^ b[31];
        n.exp  = {3'h0, a[30:23]} + {3'h0, b[30:23]} - EXP_BIAS;
        if (f_zd(a) || f_zd(b)) begin
            n.zero = 1'b1;
        end else if (p[47]) begin
            n.mant = p[47:24];
            n.g    = p[23];
            n.x    = |p[22:0];
            n.exp  = n.exp + 11'h001;
        end else begin
            n.mant = p[46:23];
            n.g    = p[22];
            n.x    = |p[21:0];
        end
        return n;
    endfunction

    // truncating add; shifted-out bits go sticky
    function automatic fp_num_s f_add(input fp_num_s p, input fp_num_s q);
        fp_num_s     n;
        fp_num_s     t;
        logic [51:0] va;
        logic [51:0] vb;
        logic [51:0] sh;
        logic [51:0] sum;
        logic [10:0] diff;
        logic        lost;
        int          lead;
        n = '0;
        if (p.zero) begin
            n = q;
        end else if (q.zero) begin
            n = p;
        end else begin
            if ({q.exp, q.mant} > {p.exp, p.mant}) begin
                t = p;
                p = q;
                q = t;
            end
            diff = p.exp - q.exp;
            va   = {1'b0, p.mant, p.g, p.x, 25'h0};
            vb   = {1'b0, q.mant, q.g, q.x, 25'h0};
            if (diff >= 11'd52) begin
                sh   = '0;
                lost = |vb;
            end else begin
                sh   = vb >> diff;
                lost = (sh << diff) != vb;
            end
            sum  = (p.sign == q.sign) ? va + sh : va - sh;
            lead = -1;
            for (int i = 0; i < 52; i++) begin
                if (sum[i]) begin
                    lead = i;
                end
            end
            n.sign = p.sign;
            if (lead < 0) begin
                n.zero = 1'b1;
            end else begin
                if (lead == 51) begin
                    lost = lost | sum[0];
                    sum  = sum >> 1;
                end else begin
                    sum = sum << (50 - lead);
                end
                n.mant = sum[50:27];
                n.g    = sum[26];
                n.x    = (|sum[25:0]) | lost;
                n.exp  = p.exp + 11'(lead) - 11'd50;
            end
        end
        return n;
    endfunction

    // restoring square root of a positive normal, truncated
    function automatic fp_num_s f_sqrt(input logic [31:0] a);
        fp_num_s     n;
        logic [49:0] rad;
        logic [26:0] rem;
        logic [24:0] root;
        logic [26:0] trial;
        logic [10:0] ue;
        n    = '0;
        ue   = {3'h0, a[30:23]} - EXP_BIAS;
        // odd unbiased exponent doubles the radicand
        rad  = ue[0] ? {1'b1, a[22:0], 26'h0} : {2'h1, a[22:0], 25'h0};
        ue   = ue[0] ? ue - 11'h001 : ue;
        rem  = '0;
        root = '0;
        for (int i = 24; i >= 0; i--) begin
            rem   = {rem[24:0], rad[2*i+1], rad[2*i]};
            trial = {root, 2'b01};
            if (rem >= trial) begin
                rem  = rem - trial;
                root = {root[23:0], 1'b1};
            end else begin
                root = {root[23:0], 1'b0};
            end
        end
        n.mant = root[24:1];
        n.g    = root[0];
        n.x    = rem != 27'h0;
        n.exp  = {ue[10], ue[10:1]} + EXP_BIAS;
        return n;
    endfunction

    // bound the exponent: overflow to max, underflow to a signed zero
    function automatic fp_elem_s f_pack(input fp_num_s n,
                                        input logic    unf_sign);
        fp_elem_s r;
        r = '0;
        if (n.zero) begin
            r.val = {n.sign, 31'h0};
        end else if (!n.exp[10] && n.exp >= EXP_LIMIT) begin
            r.ovf = 1'b1;
            r.val = f_max(n.sign);
        end else if (n.exp[10] || n.exp == 11'h000) begin
            r.unf = 1'b1;
            r.val = {unf_sign, 31'h0};
        end else begin
            r.val = {n.sign, n.exp[7:0], n.mant[22:0]};
            r.g   = n.g;
            r.x   = n.x;
            r.inx = n.g | n.x;
        end
        return r;
    endfunction

    // one element of any operation; sub selects subtract over add
    function automatic fp_elem_s f_elem(input fp_op_e      op,
                                        input logic [31:0] a,
                                        input logic [31:0] b,
                                        input logic [31:0] d,
                                        input logic [1:0]  rm,
                                        input logic        sub);
        fp_elem_s r;
        fp_num_s  p;
        logic     minus_inf;
        r         = '0;
        minus_inf = rm == ROUND_MINUS_INF;
        case (op)
            OP_NMSUB: begin
                p = f_mul(a, b);
                p.sign = ~p.sign;
                r = f_pack(f_add(f_unpack(d, 1'b0), p),
                           ~minus_inf);
                if (f_special(a) || f_special(b)) begin
                    r     = '0;
                    r.val = f_max(~(a[31] ^ b[31]));
                end
                if (f_special(d)) begin
                    r     = '0;
                    r.val = f_max(d[31]);
                end
                r.inv = f_bad(a) | f_bad(b) | f_bad(d);
            end
            OP_SQRT: begin
                if (f_zd(a)) begin
                    r.val = {a[31], 31'h0};
                end else if (a[31]) begin
                    r.val = {1'b1, 31'h0};
                end else if (f_special(a)) begin
                    r.val = f_max(1'b0);
                end else begin
                    r = f_pack(f_sqrt(a), minus_inf);
                    r.ovf = 1'b0;
                end
                r.inv = f_bad(a) | (a[31] & (a[30:0] != 31'h0));
            end
            default: begin
                r = f_pack(f_add(f_unpack(a, 1'b0), f_unpack(b, sub)),
                           minus_inf);
                if (f_special(a)) begin
                    r     = '0;
                    r.val = f_max(a[31]);
                end else if (f_special(b)) begin
                    r     = '0;
                    r.val = f_max(b[31] ^ sub);
                end
                r.inv = f_bad(a) | f_bad(b);
            end
        endcase
        // an invalid element reports nothing else
        if (r.inv) begin
            r.ovf = 1'b0;
            r.unf = 1'b0;
            r.inx = 1'b0;
        end
        return r;
    endfunction

    // both elements in parallel; subadd adds in the low element
    always_comb begin
        el_hi = f_elem(issue.op, issue.src_a[63:32], issue.src_b[63:32],
                       issue.src_d[63:32], fpscr_q.rmode, 1'b1);
        el_lo = f_elem(issue.op, issue.src_a[31:0], issue.src_b[31:0],
                       issue.src_d[31:0], fpscr_q.rmode,
                       issue.op != OP_SUBADD);
    end

    // exception decision for the whole instruction
    always_comb begin
        any_inv  = el_hi.inv | el_lo.inv;
        take_inv = any_inv & fpscr_q.invalid_exc_enable;
        take_ou  = !take_inv &&
                   ((fpscr_q.overflow_exc_enable &
                     (el_hi.ovf | el_lo.ovf)) ||
                    (fpscr_q.underflow_exc_enable &
                     (el_hi.unf | el_lo.unf)));
        // untrapped range errors count as inexact
        inx_hi   = !take_inv && !take_ou &&
                   (el_hi.inx |
                    (el_hi.ovf & !fpscr_q.overflow_exc_enable) |
                    (el_hi.unf & !fpscr_q.underflow_exc_enable));
        inx_lo   = !take_inv && !take_ou &&
                   (el_lo.inx |
                    (el_lo.ovf & !fpscr_q.overflow_exc_enable) |
                    (el_lo.unf & !fpscr_q.underflow_exc_enable));
        take_rnd = (inx_hi | inx_lo) & fpscr_q.inexact_exc_enable;
        do_write = !take_inv && !take_ou;
        events   = '0;
        events[IRQ_INVALID] = take_inv;
        events[IRQ_OVF_UNF] = take_ou;
        events[IRQ_ROUND]   = take_rnd;
        events[IRQ_DONE]    = 1'b1;
    end

    // write-back and traps, one cycle after issue
    always_ff @(posedge core_clk) begin
        if (rst) begin
            result_valid_q <= 1'b0;
            result_we_q    <= 1'b0;
            result_q       <= 64'h0;
            exc_invalid_q  <= 1'b0;
            exc_ovf_unf_q  <= 1'b0;
            exc_round_q    <= 1'b0;
        end else if (clk_en) begin
            result_valid_q <= issue_valid;
            result_we_q    <= issue_valid & do_write;
            exc_invalid_q  <= issue_valid & take_inv;
            exc_ovf_unf_q  <= issue_valid & take_ou;
            exc_round_q    <= issue_valid & take_rnd;
            // truncated value is written even when rounding traps
            if (issue_valid) begin
                result_q <= {el_hi.val, el_lo.val};
            end
        end
    end

    // status/control: issue updates win
    always_ff @(posedge core_clk) begin
        if (rst) begin
            fpscr_q <= FPSCR_RESET;
        end else if (clk_en) begin
            if (reg_wr && reg_addr == OFS_FPSCR) begin
                fpscr_q         <= reg_wdata;
                fpscr_q.rsv_hi  <= '0;
                fpscr_q.rsv_mid <= '0;
            end
            if (issue_valid) begin
                fpscr_q.invalid_flag_high   <= el_hi.inv;
                fpscr_q.invalid_flag_low    <= el_lo.inv;
                fpscr_q.overflow_flag_high  <= el_hi.ovf & !any_inv;
                fpscr_q.overflow_flag_low   <= el_lo.ovf & !any_inv;
                fpscr_q.underflow_flag_high <= el_hi.unf & !any_inv;
                fpscr_q.underflow_flag_low  <= el_lo.unf & !any_inv;
                // guard bits are dropped when they cannot help a handler
                fpscr_q.guard_bit_high  <= el_hi.g & !el_hi.inv &
                                           !take_ou;
                fpscr_q.sticky_bit_high <= el_hi.x & !el_hi.inv &
                                           !take_ou;
                fpscr_q.guard_bit_low   <= el_lo.g & !el_lo.inv &
                                           !take_ou;
                fpscr_q.sticky_bit_low  <= el_lo.x & !el_lo.inv &
                                           !take_ou;
                // sticky: set wins over a same-cycle software clear
                if (inx_hi | inx_lo) begin
                    fpscr_q.inexact_sticky_low <= 1'b1;
                    if (issue.op == OP_SQRT) begin
                        fpscr_q.inexact_sticky_high <= 1'b1;
                    end
                end
            end
        end
    end

    // interrupt status, write one to clear, event set wins
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_stat_q <= IRQ_RESET;
        end else if (clk_en) begin
            irq_stat_q <= (irq_stat_q &
                           ~((reg_wr && reg_addr == OFS_IRQ_STAT) ?
                             reg_wdata[3:0] : 4'h0)) |
                          (issue_valid ? events : 4'h0);
        end
    end

    // interrupt mask
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_mask_q <= IRQ_RESET;
        end else if (clk_en) begin
            if (reg_wr && reg_addr == OFS_IRQ_MASK) begin
                irq_mask_q <= reg_wdata[3:0];
            end
        end
    end

    // level interrupt, one cycle behind the status bits
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else if (clk_en) begin
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    // read data stands one cycle only
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata_q <= 32'h0;
        end else if (clk_en) begin
            if (!reg_rd) begin
                reg_rdata_q <= 32'h0;
            end else if (reg_addr == OFS_FPSCR) begin
                reg_rdata_q <= fpscr_q;
            end else if (reg_addr == OFS_IRQ_STAT) begin
                reg_rdata_q <= {28'h0, irq_stat_q};
            end else if (reg_addr == OFS_IRQ_MASK) begin
                reg_rdata_q <= {28'h0, irq_mask_q};
            end else begin
                reg_rdata_q <= 32'h0; // unmapped reads zero
            end
        end
    end

endmodule

//--- testbench/fp_core_model.sv
// core side: destination slot
// assumes we stays low on a cancel
`timescale 1ns/10ps
module fp_core_model (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // write-back
    input  wire logic        result_we_q,
    input  wire logic [63:0] result_q,
    // destination slot
    output logic      [63:0] dest_q
);
    // moves on write-back only
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dest_q <= 64'h0;
        end else if (result_we_q) begin
            dest_q <= result_q;
        end
    end
endmodule

//--- testbench/fp_pair_unit_monitor.sv
// port assertions for the paired float unit
// assumes sync active-high reset
`timescale 1ns/10ps
module fp_pair_unit_monitor
    import fp_pair_pkg::*;
(
    // clock, reset, enable
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        clk_en,
    // issue
    input wire logic        issue_valid,
    input wire fp_issue_s   issue,
    // write-back and traps
    input wire logic        result_valid_q,
    input wire logic        result_we_q,
    input wire logic [63:0] result_q,
    input wire logic        exc_invalid_q,
    input wire logic        exc_ovf_unf_q,
    input wire logic        exc_round_q,
    // register read
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata_q
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // issue taken only while enabled
    wire logic tk = clk_en && issue_valid;
    wire logic sq = tk && (issue.op == OP_SQRT);
    property p_answer; tk |=> result_valid_q; endproperty
    a_answer: assert property (p_answer) else $error("no result");
    property p_hold;
        clk_en && !issue_valid |=> !result_valid_q && $stable(result_q);
    endproperty
    a_hold: assert property (p_hold) else $error("result moved");
    property p_we; result_we_q |-> result_valid_q; endproperty
    a_we: assert property (p_we) else $error("stray write");
    property p_inv; exc_invalid_q |-> !result_we_q; endproperty
    a_inv: assert property (p_inv) else $error("invalid trap wrote");
    property p_ovf; exc_ovf_unf_q |-> !result_we_q; endproperty
    a_ovf: assert property (p_ovf) else $error("ovf trap wrote");
    property p_rnd;
        exc_round_q |-> result_we_q && !exc_invalid_q && !exc_ovf_unf_q;
    endproperty
    a_rnd: assert property (p_rnd) else $error("round trap bad");
    property p_sqo; sq |=> !exc_ovf_unf_q; endproperty
    a_sqo: assert property (p_sqo) else $error("sqrt overflowed");
    property p_sqm;
        sq && issue.src_a[63:55] == {1'b0, EXP_SPECIAL}
            |=> !result_we_q || result_q[63:32] == 32'h7F7FFFFF;
    endproperty
    a_sqm: assert property (p_sqm) else $error("sqrt +special");
    property p_rdz; clk_en && !reg_rd |=> reg_rdata_q == 32'h0; endproperty
    a_rdz: assert property (p_rdz) else $error("read data not idle");
endmodule

bind fp_pair_unit fp_pair_unit_monitor u_mon (
    .core_clk, .rst, .clk_en, .issue_valid, .issue, .result_valid_q,
    .result_we_q, .result_q, .exc_invalid_q, .exc_ovf_unf_q,
    .exc_round_q, .reg_rd, .reg_rdata_q
);

//--- testbench/vector_sp_float_nmsub_sqrt_sub_tb_top.sv
// bench: issues, register traffic, in-order watcher
// assumes answers one cycle after each request
`timescale 1ns/10ps
module vector_sp_float_nmsub_sqrt_sub_tb_top
    import fp_pair_pkg::*;
;
    // expected {we,inv,ovf,rnd}, value, mask
    typedef struct packed {
        logic [3:0]  flg;
        logic [63:0] val;
        logic [63:0] msk;
    } note_s;
    localparam logic [31:0] PMAX = 32'h7F7FFFFF;
    localparam logic [31:0] NMAX = 32'hFF7FFFFF;
    localparam logic [31:0] PINF = 32'h7F800000;
    localparam logic [31:0] NINF = 32'hFF800000;
    localparam logic [31:0] ONE  = 32'h3F800000;
    localparam logic [31:0] NZ   = 32'h80000000;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        clk_en = 1'b1;
    logic        issue_valid = 1'b0;
    fp_issue_s   issue = '0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        result_valid_q, result_we_q, irq_q, rd_p = 1'b0;
    logic        exc_invalid_q, exc_ovf_unf_q, exc_round_q;
    logic [63:0] result_q, dest_q;
    logic [31:0] reg_rdata_q, x;
    int          mismatches = 0;
    int          n_compared = 0;
    int          seed = 75073;
    note_s       rq[$], dq[$], n;

    always #12.5 core_clk = ~core_clk;

    fp_pair_unit u_dut (
        .core_clk, .rst, .clk_en, .issue_valid, .issue,
        .result_valid_q, .result_we_q, .result_q, .exc_invalid_q,
        .exc_ovf_unf_q, .exc_round_q, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata_q, .irq_q
    );
    fp_core_model u_core (
        .core_clk, .rst, .result_we_q, .result_q, .dest_q
    );

    task automatic chk(logic [63:0] seen, logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // one issue; value masked off if cancelled
    task automatic go(fp_op_e op, logic [63:0] a, b, d,
                      logic [3:0] f, logic [63:0] r);
        issue_valid <= 1'b1;
        issue <= '{op, a, b, d};
        rq.push_back('{f, r, {64{f[3]}}});
        @(posedge core_clk);
        issue_valid <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(logic [3:0] a, logic [31:0] v, logic [31:0] m);
        reg_rd <= 1'b1;
        reg_addr <= a;
        dq.push_back('{4'h0, {32'h0, v}, {32'h0, m}});
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(logic [3:0] a, logic [31:0] v);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    // irq settles after the edge
    task automatic irq_is(logic v);
        #1;
        chk({63'h0, irq_q}, {63'h0, v});
        @(posedge core_clk);
    endtask
    task automatic fin(string s);
        repeat (3) @(posedge core_clk);
        $display("test %s done", s);
    endtask

    // watcher: oldest note per answer
    always @(posedge core_clk) begin
        if (rd_p) begin
            n = dq.pop_front();
            chk({32'h0, reg_rdata_q} & n.msk, n.val & n.msk);
        end
        if (result_valid_q) begin
            n = rq.pop_front();
            chk({result_we_q, exc_invalid_q, exc_ovf_unf_q, exc_round_q},
                n.flg);
            chk(result_q & n.msk, n.val & n.msk);
        end
        rd_p = reg_rd;
    end

    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        for (int i = 0; i < 16; i += 4) begin
            rd(4'(i), 32'h0, '1);
        end
        wr(OFS_IRQ_MASK, 32'h8);
        go(OP_SUB, {32'h40400000, PINF}, {2{ONE}}, 0, 4'h8,
           {32'h40000000, PMAX});
        rd(OFS_FPSCR, 32'h1, 32'h3FF);
        irq_is(1'b1);
        wr(OFS_IRQ_MASK, 32'h0);
        irq_is(1'b0);
        wr(OFS_IRQ_MASK, 32'h8);
        irq_is(1'b1);
        wr(OFS_IRQ_STAT, 32'h8);
        irq_is(1'b0);
        go(OP_SUB, {2{ONE}}, {PINF, NINF}, 0, 4'h8, {NMAX, PMAX});
        go(OP_SUBADD, {2{32'h40400000}}, {2{ONE}}, 0, 4'h8,
           {32'h40000000, 32'h40800000});
        go(OP_NMSUB, {32'h40000000, 32'h0}, {32'h40400000, 32'h40A00000},
           {2{ONE}}, 4'h8, {32'hC0A00000, ONE});
        go(OP_NMSUB, {PINF, NINF}, {2{ONE}}, 0, 4'h8, {NMAX, PMAX});
        go(OP_NMSUB, {2{ONE}}, {2{ONE}}, {PINF, NINF}, 4'h8,
           {PMAX, NMAX});
        fin("ops");
        go(OP_SQRT, {32'h41100000, 32'h40800000}, 0, 0, 4'h8,
           {32'h40400000, 32'h40000000});
        go(OP_SQRT, {PINF, 32'hC0800000}, 0, 0, 4'h8, {PMAX, NZ});
        rd(OFS_FPSCR, 32'h3, 32'h3FF);
        go(OP_SQRT, {NZ, 32'h1}, 0, 0, 4'h8, {NZ, 32'h0});
        go(OP_SQRT, {2{32'h40000000}}, 0, 0, 4'h8, {2{32'h3FB504F3}});
        rd(OFS_FPSCR, 32'hC00, 32'hC00);
        fin("sqrt");
        wr(OFS_FPSCR, 32'h0);
        go(OP_SUB, {PMAX, NMAX}, {NMAX, PMAX}, 0, 4'h8, {PMAX, NMAX});
        rd(OFS_FPSCR, 32'h40C, 32'hC3F);
        wr(OFS_FPSCR, 32'h20000);
        go(OP_SUB, {PMAX, NMAX}, {NMAX, PMAX}, 0, 4'h2, 0);
        rd(OFS_FPSCR, 32'h2000C, 32'hF0FFF);
        fin("overflow");
        for (int m = 0; m < 4; m++) begin
            wr(OFS_FPSCR, {10'h0, m[1:0], 20'h0});
            go(OP_NMSUB, {2{32'h0D800000}}, {2{32'h0D800000}}, 0, 4'h8,
               {2{(m == 3) ? 32'h0 : NZ}});
            go(OP_SUB, {2{32'h00800000}}, {2{32'h00C00000}}, 0, 4'h8,
               {2{(m == 3) ? NZ : 32'h0}});
        end
        fin("underflow");
        wr(OFS_FPSCR, 32'h80000);
        go(OP_SUB, {2{ONE}}, {2{32'h30800000}}, 0, 4'h9,
           {2{32'h3F7FFFFF}});
        rd(OFS_FPSCR, 32'h807C0, 32'hF0FFF);
        rd(OFS_IRQ_STAT, 32'hE, '1);
        wr(OFS_FPSCR, 32'h10000);
        go(OP_SUB, {PINF, ONE}, {2{ONE}}, 0, 4'h4, 0);
        fin("traps");
        chk(dest_q, {2{32'h3F7FFFFF}});
        wr(OFS_FPSCR, 32'h0);
        // back-to-back random x - 0
        for (int i = 0; i < 8; i++) begin
            x = $random(seed);
            x[30:29] = 2'b01;
            issue_valid <= 1'b1;
            issue <= '{OP_SUB, {x, ~x}, 64'h0, 64'h0};
            rq.push_back('{4'h8, {x, ~x}, '1});
            @(posedge core_clk);
        end
        issue_valid <= 1'b0;
        fin("random");
        report_and_stop();
    end

    // hang guard
    initial begin
        #(25 * 2000);
        mismatches++;
        report_and_stop();
    end
endmodule
